// ===== rtl/btm_timer.sv
`timescale 1ns/10ps
// Function
// - Freeze bit set halts counting in debug
// - Freeze bit clear keeps counting in debug
// - Mode 0 counts prescaled clock
// - Mode 1 counts trigger source events
// - Mode 2 trigger event starts counter
// - Mode 3 pin level gates counting
// - Single-shot bit selects single or continuous
// - Source select 0 uses external pin
// - Source select 1 uses cascade input
// - Counter mode pin edge chosen by polarity; cascade counts rising edges only
// - Trigger start pin edge chosen by polarity; cascade starts on rising edge only
// - Gate active level chosen by polarity
// - Overflow interrupt only when enabled
// - Trigger interrupt only when enabled
// - Writing zero clears a flag
// - Run bit starts trigger mode immediately
// - One clock enable gates all timers; each timer here keeps its own copy of it
// - Reaching reload value sets overflow flag
// - Prescaler divides by two to field
// - Pin filter needs N equal samples
`include "btm_defines.svh"

module btm_timer
  import btm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        debug_halt_i,
  input  wire logic        external_trigger_pin_i,
  input  wire logic        cascade_input_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hsel_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             irq_o,
  output logic             overflow_o
);

  // Bus address phase capture
  logic             wr_q, rd_q;
  logic [11:0]      addr_q;
  logic             acc_ok;
  assign acc_ok = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_q   <= acc_ok && hwrite_i;
      rd_q   <= acc_ok && !hwrite_i;
      addr_q <= haddr_i[11:0];
    end
  end

  // No wait states and no errors; size is not decoded, every access is a word
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // Writes land at the end of the data phase, while hwdata stands
  function automatic logic wr_hit(input logic [11:0] off);
    return wr_q && (addr_q == off);
  endfunction : wr_hit

  // Registers
  logic [CNT_W-1:0] reload_q, count_q;
  logic [2:0]       filter_q;
  logic             run_q, single_q, tog_q, src_q, polarity_q;
  logic [1:0]       mode_q;
  logic [3:0]       div_q, div_act_q;
  logic [1:0]       irq_en_q, flags_q;
  logic [31:0]      dma_q;
  logic             clk_en_q, freeze_q;
  btm_mode_e        mode;
  assign mode = btm_mode_e'(mode_q);

  // Shared enable gates register writes and counting alike
  logic reg_we;
  assign reg_we = clk_en_q;

  // System word: one copy per timer here, though the system shares a single one
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clk_en_q <= 1'b0;
      freeze_q <= 1'b0;
    end else if (wr_hit(`BTM_OFF_SYSCTRL)) begin
      clk_en_q <= hwdata_i[`BTM_SYS_CLKEN];
      freeze_q <= hwdata_i[`BTM_SYS_FREEZE];
    end
  end

  // Pin and cascade synchronisers
  // Only the second stage feeds logic; the first may still be settling
  logic [1:0] pin_sync_q, casc_sync_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_sync_q  <= 2'b00;
      casc_sync_q <= 2'b00;
    end else begin
      pin_sync_q  <= {pin_sync_q[0], external_trigger_pin_i};
      casc_sync_q <= {casc_sync_q[0], cascade_input_i};
    end
  end

  // Pin filter: N equal samples at PCLK, /4 or /16
  // A change must persist for N samples before the filtered level follows
  logic [3:0] fdiv_q;
  logic [2:0] frun_q;
  logic       pin_flt_q, fsample;
  logic [2:0] need;
  always_comb begin
    unique case (filter_q)
      3'h1:    need = 3'h2;
      3'h2,
      3'h4,
      3'h6:    need = 3'h4;
      default: need = 3'h6;
    endcase
  end
  always_comb begin
    if (filter_q[2:1] == 2'b10)
      fsample = (fdiv_q[1:0] == 2'h3);
    else if (filter_q[2:1] == 2'b11)
      fsample = (fdiv_q == 4'hF);
    else
      fsample = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fdiv_q    <= 4'h0;
      frun_q    <= 3'h0;
      pin_flt_q <= 1'b0;
    end else begin
      fdiv_q <= fdiv_q + 4'h1;
      if (filter_q == 3'h0) begin
        pin_flt_q <= pin_sync_q[1];
        frun_q    <= 3'h0;
      end else if (fsample) begin
        if (pin_sync_q[1] == pin_flt_q) begin
          frun_q <= 3'h0;
        end else if (frun_q + 3'h1 >= need) begin
          pin_flt_q <= pin_sync_q[1];
          frun_q    <= 3'h0;
        end else begin
          frun_q <= frun_q + 3'h1;
        end
      end
    end
  end

  // Edge detection with polarity
  // Reset low matches the idle pin, so no false edge follows reset
  logic pin_prev_q, casc_prev_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_prev_q  <= 1'b0;
      casc_prev_q <= 1'b0;
    end else begin
      pin_prev_q  <= pin_flt_q;
      casc_prev_q <= casc_sync_q[1];
    end
  end

  logic pin_edge, casc_edge, trig_evt, gate_on;
  // Polarity 0 rising, 1 falling on the pin; the cascade edge is always rising
  assign pin_edge  = polarity_q ? (pin_prev_q && !pin_flt_q) : (!pin_prev_q && pin_flt_q);
  assign casc_edge = casc_sync_q[1] && !casc_prev_q;
  assign trig_evt  = src_q ? casc_edge : pin_edge;
  assign gate_on   = pin_flt_q ^ polarity_q;

  // Prescaler
  logic [14:0] pre_q;
  logic [3:0]  div_sel;
  logic        pre_tick;
  logic        active;
  logic        run_prev_q;
  // The first cycle of a run already divides by the new setting, not the stale one
  assign div_sel  = (run_q && !run_prev_q) ? div_q : div_act_q;
  assign pre_tick = (pre_q >= 15'((32'h1 << div_sel) - 32'h1));
  // Freeze only while the debugger holds the core
  assign active   = clk_en_q && !(freeze_q && debug_halt_i);

  logic trig_start, step, ovf;
  assign trig_start = active && (mode == BTM_MODE_TRIGGER) && trig_evt;

  always_comb begin
    unique case (mode)
      BTM_MODE_TIMER:   step = pre_tick;
      BTM_MODE_COUNTER: step = trig_evt;
      BTM_MODE_TRIGGER: step = pre_tick;
      BTM_MODE_GATED:   step = pre_tick && gate_on;
    endcase
  end

  logic counting;
  assign counting = active && run_q;
  assign ovf      = counting && step && (count_q == reload_q);

  // Held at zero while stopped, so each run begins on a full period
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_q <= 15'h0000;
    end else if (!counting || pre_tick) begin
      pre_q <= 15'h0000;
    end else begin
      pre_q <= pre_q + 15'h0001;
    end
  end

  // A software preset wins over a count step in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_q <= '0;
    end else if (reg_we && wr_hit(`BTM_OFF_COUNT)) begin
      count_q <= hwdata_i[CNT_W-1:0];
    end else if (ovf) begin
      count_q <= '0;
    end else if (counting && step) begin
      count_q <= count_q + 1'b1;
    end
  end

  // Control registers
  logic run_wr;
  assign run_wr = reg_we && wr_hit(`BTM_OFF_BASICCTRL);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run_q    <= 1'b0;
      mode_q   <= 2'h0;
      src_q    <= 1'b0;
      polarity_q <= 1'b0;
      single_q <= 1'b0;
      tog_q    <= 1'b0;
      div_q    <= 4'h0;
    end else begin
      if (run_wr) begin
        mode_q   <= hwdata_i[`BTM_BCR_MODE_LO +: 2];
        src_q    <= hwdata_i[`BTM_BCR_SRC];
        polarity_q <= hwdata_i[`BTM_BCR_INVERT];
        single_q <= hwdata_i[`BTM_BCR_SINGLE];
        tog_q    <= hwdata_i[`BTM_BCR_TOGEN];
        div_q    <= hwdata_i[`BTM_BCR_DIV_LO +: 4];
      end
      // A trigger in the cycle a single shot ends keeps the timer running
      if (trig_start)
        run_q <= 1'b1;
      else if (ovf && single_q)
        run_q <= 1'b0;
      else if (run_wr)
        run_q <= hwdata_i[`BTM_BCR_EN];
    end
  end

  // Prescale status reloads on overflow or run rising
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run_prev_q <= 1'b0;
      div_act_q  <= 4'h0;
    end else begin
      run_prev_q <= run_q;
      if (ovf || (run_q && !run_prev_q))
        div_act_q <= div_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reload_q <= CNT_W'(`BTM_RST_RELOAD);
      filter_q <= 3'h0;
      irq_en_q <= 2'h0;
      dma_q    <= 32'h0000_0000;
    end else if (reg_we) begin
      if (wr_hit(`BTM_OFF_RELOAD))
        reload_q <= hwdata_i[CNT_W-1:0];
      if (wr_hit(`BTM_OFF_ADVCTRL))
        filter_q <= hwdata_i[`BTM_ACR_FLT_LO +: 3];
      if (wr_hit(`BTM_OFF_IRQEN))
        irq_en_q <= hwdata_i[1:0];
      if (wr_hit(`BTM_OFF_DMASEL))
        dma_q <= hwdata_i;
    end
  end

  // Flags: a hardware set in the clearing cycle wins
  logic [1:0] clr_mask, set_mask;
  assign clr_mask = (reg_we && wr_hit(`BTM_OFF_IRQCLR)) ? ~hwdata_i[1:0] : 2'h0;
  assign set_mask = {trig_start, ovf};

  always_ff @(posedge clk_i) begin
    if (reset_i)
      flags_q <= 2'h0;
    else
      flags_q <= (flags_q & ~clr_mask) | set_mask;
  end

  // Level output: stays high until software clears the flag or the enable
  assign irq_o = |(flags_q & irq_en_q);

  // One-cycle pulse a clock after the wrap, fit to feed another timer's cascade
  always_ff @(posedge clk_i) begin
    if (reset_i)
      overflow_o <= 1'b0;
    else
      overflow_o <= ovf;
  end

  // Read data, registered in the address phase so it stands through the data phase
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (acc_ok && !hwrite_i) begin
      unique case (haddr_i[11:0])
        `BTM_OFF_RELOAD:    hrdata_o <= 32'(reload_q);
        `BTM_OFF_COUNT:     hrdata_o <= 32'(count_q);
        `BTM_OFF_ADVCTRL:   hrdata_o <= {25'h0, filter_q, 4'h0};
        `BTM_OFF_BASICCTRL: hrdata_o <= {17'h0, div_act_q, div_q, tog_q,
                                         single_q, polarity_q, src_q, mode_q, run_q};
        `BTM_OFF_IRQEN:     hrdata_o <= {30'h0, irq_en_q};
        `BTM_OFF_IRQFLAGS:  hrdata_o <= {30'h0, flags_q};
        `BTM_OFF_DMASEL:    hrdata_o <= dma_q;
        `BTM_OFF_SYSCTRL:   hrdata_o <= {30'h0, freeze_q, clk_en_q};
        default:            hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : btm_timer

// ===== rtl/btm_defines.svh
`ifndef BTM_DEFINES_SVH
`define BTM_DEFINES_SVH

`define BTM_OFF_RELOAD     12'h000
`define BTM_OFF_COUNT      12'h004
`define BTM_OFF_ADVCTRL    12'h00C
`define BTM_OFF_BASICCTRL  12'h010
`define BTM_OFF_IRQEN      12'h014
`define BTM_OFF_IRQFLAGS   12'h018
`define BTM_OFF_IRQCLR     12'h01C
`define BTM_OFF_DMASEL     12'h020
`define BTM_OFF_SYSCTRL    12'h024

`define BTM_RST_RELOAD     16'hFFFF

`define BTM_BCR_EN         0
`define BTM_BCR_MODE_LO    1
`define BTM_BCR_SRC        3
`define BTM_BCR_INVERT     4
`define BTM_BCR_SINGLE     5
`define BTM_BCR_TOGEN      6
`define BTM_BCR_DIV_LO     7
`define BTM_BCR_DIVST_LO   11
`define BTM_ACR_FLT_LO     4

`define BTM_IRQ_WRAP       0
`define BTM_IRQ_TRIG       1

`define BTM_SYS_CLKEN      0
`define BTM_SYS_FREEZE     1

`endif

// ===== rtl/btm_pkg.sv
package btm_pkg;
  typedef enum logic [1:0] {
    BTM_MODE_TIMER   = 2'h0,
    BTM_MODE_COUNTER = 2'h1,
    BTM_MODE_TRIGGER = 2'h2,
    BTM_MODE_GATED   = 2'h3
  } btm_mode_e;
endpackage : btm_pkg

// ===== sim/btm_timer_sva.sv
`timescale 1ns/10ps
module btm_timer_sva (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        debug_halt_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hsel_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        irq_o,
  input wire logic        overflow_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic       go;
  logic       rd;
  logic       wr_q;
  logic [7:0] a_q;
  logic [1:0] sys_q;
  assign go = hsel_i && hready_i && htrans_i[1];
  assign rd = go && !hwrite_i;
  // Shadow of the system word, so freeze and gating are judged from the pins alone
  always_ff @(posedge clk_i) begin
    if (go) begin
      a_q <= haddr_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q  <= 1'b0;
      sys_q <= 2'h0;
    end else begin
      wr_q <= go && hwrite_i;
      if (wr_q && a_q == 8'h24) begin
        sys_q <= hwdata_i[1:0];
      end
    end
  end
  AST_FREEZE: assert property ((sys_q == 2'h3 && debug_halt_i) [*3] |-> !overflow_o)
    else $error("overflow while frozen");
  AST_CLKGATE: assert property (!sys_q[0] [*3] |-> !overflow_o)
    else $error("overflow with clock gated");
  AST_WRAP_PULSE: assert property (overflow_o |=> !overflow_o)
    else $error("overflow pulse too long");
  AST_RST: assert property (disable iff (1'b0)
    reset_i |=> !irq_o && !overflow_o && hrdata_o == 32'h0) else $error("reset not quiet");
  AST_BUS: assert property (hreadyout_o && !hresp_o)
    else $error("wait state or error response");
  AST_UNMAP: assert property (rd && haddr_i[7:0] == 8'h28 |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_BCR_RSV: assert property (rd && haddr_i[7:0] == 8'h10 |=> hrdata_o[31:15] == 17'h0)
    else $error("control reserved bits set");
  AST_RLD_RSV: assert property (rd && haddr_i[7:0] == 8'h00 |=> hrdata_o[31:16] == 16'h0)
    else $error("reload upper bits set");
  cover property (overflow_o);
  cover property (irq_o);
  cover property (sys_q == 2'h3 && debug_halt_i);
endmodule : btm_timer_sva

bind btm_timer btm_timer_sva btm_timer_sva_inst (
  .clk_i, .reset_i, .debug_halt_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
  .hsel_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .irq_o, .overflow_o
);

// ===== sim/btm_pin.sv
`timescale 1ns/10ps
module btm_pin (
  input  wire logic clk_i,
  output logic      pin_o,
  output logic      casc_o
);
  initial begin
    pin_o  = 1'b0;
    casc_o = 1'b0;
  end
  // Driven levels, never floating; w sets how slowly the far side moves
  task automatic toggle(input logic casc, input int n, input int w);
    repeat (n) begin
      @(posedge clk_i);
      if (casc) begin
        casc_o <= !casc_o;
      end else begin
        pin_o <= !pin_o;
      end
      repeat (w - 1) @(posedge clk_i);
    end
  endtask : toggle
endmodule : btm_pin

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        debug_halt_i = 1'b0;
  logic        hwrite_i = 1'b0;
  logic        rd_dp = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic [31:0] exp_q[$];
  logic        external_trigger_pin_i, cascade_input_i, hreadyout_o, hresp_o, irq_o, overflow_o;
  int          err_count = 0;
  int          check_count = 0;
  int          wrap_n = 0;
  int          n, r, prev;
  btm_timer btm_timer_inst (
    .clk_i, .reset_i, .debug_halt_i, .external_trigger_pin_i, .cascade_input_i,
    .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hsel_i(1'b1),
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .irq_o, .overflow_o
  );
  btm_pin btm_pin_inst (.clk_i, .pin_o(external_trigger_pin_i), .casc_o(cascade_input_i));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdy();
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
  endtask : rdy
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    haddr_i  <= {24'h0, a};
    hwrite_i <= 1'b1;
    htrans_i <= 2'h2;
    rdy();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rdy();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    haddr_i  <= {24'h0, a};
    hwrite_i <= 1'b0;
    htrans_i <= 2'h2;
    rdy();
    exp_q.push_back(e);
    rd_dp    <= 1'b1;
    htrans_i <= 2'h0;
    rdy();
    rd_dp <= 1'b0;
  endtask : rd
  task automatic wait_ov(output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (overflow_o !== 1'b1 && k < 2000);
  endtask : wait_ov
  task automatic conclude();
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  always @(posedge clk_i) begin
    if (rd_dp === 1'b1) begin
      chk(hrdata_o, exp_q.pop_front());
    end
    if (overflow_o === 1'b1) begin
      wrap_n++;
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(68358));
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    wr(8'h00, 32'h5);
    rd(8'h00, 32'hFFFF);
    rd(8'h28, 32'h0);
    wr(8'h24, 32'h1);
    for (int p = 0; p < 2; p++) begin
      wr(8'h10, 32'(p * 16));
      wr(8'h04, 32'h0);
      wr(8'h10, 32'(p * 16 + 3));
      btm_pin_inst.toggle(1'b0, 5, 4);
      repeat (8) @(posedge clk_i);
      rd(8'h04, 32'h3);
    end
    wr(8'h10, 32'h8);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'hB);
    btm_pin_inst.toggle(1'b1, 8, 3);
    repeat (8) @(posedge clk_i);
    rd(8'h04, 32'h4);
    wr(8'h10, 32'h10);
    wr(8'h1C, 32'h0);
    wr(8'h14, 32'h2);
    wr(8'h10, 32'h14);
    btm_pin_inst.toggle(1'b0, 1, 6);
    repeat (8) @(posedge clk_i);
    rd(8'h18, 32'h0);
    btm_pin_inst.toggle(1'b0, 1, 6);
    repeat (8) @(posedge clk_i);
    rd(8'h18, 32'h2);
    rd(8'h10, 32'h15);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h1C, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h7);
    repeat (10) @(posedge clk_i);
    btm_pin_inst.toggle(1'b0, 2, 10);
    repeat (8) @(posedge clk_i);
    rd(8'h04, 32'hA);
    wr(8'h10, 32'h0);
    r = $urandom_range(20, 4);
    wr(8'h00, 32'(r));
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h81);
    wait_ov(n);
    wait_ov(n);
    chk(32'(n), 32'((r + 1) * 2));
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h10, 32'h0);
    rd(8'h18, 32'h1);
    wr(8'h1C, 32'hFFFFFFFE);
    rd(8'h18, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h04, 32'h5);
    rd(8'h04, 32'h5);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h0);
    prev = wrap_n;
    wr(8'h10, 32'h25);
    repeat (30) @(posedge clk_i);
    chk(32'(wrap_n - prev), 32'h1);
    rd(8'h10, 32'h24);
    wr(8'h24, 32'h3);
    debug_halt_i <= 1'b1;
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h1);
    repeat (20) @(posedge clk_i);
    rd(8'h04, 32'h0);
    prev = wrap_n;
    wr(8'h24, 32'h1);
    repeat (20) @(posedge clk_i);
    chk({31'h0, wrap_n != prev}, 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h1);
    wr(8'h24, 32'h0);
    wr(8'h04, 32'h2);
    rd(8'h04, 32'h1);
    debug_halt_i <= 1'b0;
    conclude();
  end
endmodule : tb
